// >>> hw/sca_pkg.sv
// Constants, types and helpers of the supply control-source arbiter.
// Assumes a single 50 MHz system clock shared by every user.
package sca_pkg;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_HZ = 50_000_000;
    localparam int ALT_TIME_MS = 500;
    localparam int ALT_HOLD_CYCLES = (CLK_HZ / 1000) * ALT_TIME_MS;
    localparam int DEB_TIME_US = 1000;
    // Least time, so rounded up
    localparam int DEB_HOLD_CYCLES =
        ((CLK_HZ / 1000) * DEB_TIME_US + 999) / 1000;

    // ------------------------------------------------------------
    // Widths and default values
    // ------------------------------------------------------------
    localparam int SET_W = 12;
    localparam int OUT_W = 16;
    localparam int RATE_W = 16;
    localparam logic [OUT_W-1:0] NOM_VOLTAGE_DEF = 16'h8000;
    localparam logic [OUT_W-1:0] NOM_CURRENT_DEF = 16'h8000;

    // ------------------------------------------------------------
    // Control source
    // ------------------------------------------------------------
    typedef enum logic [1:0]
    {
        SCA_PANEL = 2'h0,
        SCA_ANALOG = 2'h1,
        SCA_HOST = 2'h3
    } sca_mode_e;

    localparam sca_mode_e MODE_RESET = SCA_PANEL;

    // Linear map of an analog code onto zero to 4095/4096 of nominal
    function automatic logic [OUT_W-1:0] sca_scale(
        input logic [SET_W-1:0] code,
        input logic [OUT_W-1:0] nominal
    );
        logic [SET_W+OUT_W-1:0] prod;
        prod = code * nominal;
        return prod[SET_W+OUT_W-1:SET_W];
    endfunction : sca_scale

endpackage : sca_pkg

// >>> hw/sca_debounce.sv
// Synchroniser and debouncer for one slow input.
// Assumes the input is free to change at any time.
`timescale 1ns/1ps

module sca_debounce
    import sca_pkg::*;
#(
    parameter int CYCLES = DEB_HOLD_CYCLES
)
(
    input wire logic clock,
    input wire logic rst,
    input wire logic raw,
    output logic level,
    output logic rise
);

    localparam int CW = $clog2(CYCLES + 1);
    localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

    typedef struct packed
    {
        logic sync1;
        logic sync2;
        logic stable;
        logic rise;
        logic [CW-1:0] count;
    } sca_deb_s;

    sca_deb_s s;
    sca_deb_s next_s;

    // ------------------------------------------------------------
    // Filter
    // ------------------------------------------------------------
    always_comb
    begin
        next_s = s;
        next_s.sync1 = raw;
        next_s.sync2 = s.sync1;
        next_s.rise = 1'b0;
        if (s.sync2 == s.stable)
        begin
            next_s.count = '0;
        end
        else if (s.count == LAST)
        begin
            next_s.stable = s.sync2;
            next_s.rise = s.sync2;
            next_s.count = '0;
        end
        else
        begin
            next_s.count = s.count + 1'b1;
        end
    end

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            s <= '0;
        end
        else
        begin
            s <= next_s;
        end
    end

    assign level = s.stable;
    assign rise = s.rise;

    a_rise_is_edge: assert property (@(posedge clock) disable iff (rst)
        rise |-> level && !$past(level))
        else $error("debounce rise without a level edge");

endmodule : sca_debounce

// >>> hw/sca_arbiter.sv
// Control-source arbiter and blocking-error latch of the supply.
// Assumes host commands arrive decoded as one-cycle strobes and
// that analog codes and panel setpoints are already digitised.
`timescale 1ns/1ps

module sca_arbiter
    import sca_pkg::*;
#(
    parameter int ALT_CYCLES = ALT_HOLD_CYCLES,
    parameter int DEB_CYCLES = DEB_HOLD_CYCLES,
    parameter logic [OUT_W-1:0] NOMINAL_VOLTAGE = NOM_VOLTAGE_DEF,
    parameter logic [OUT_W-1:0] NOMINAL_CURRENT = NOM_CURRENT_DEF
)
(
    input wire logic clock,
    input wire logic rst,
    input wire logic hasPanel,
    input wire logic storedAnalog,
    input wire logic pullupDisableOption,
    input wire logic disableLine,
    input wire logic disableLineOpen,
    input wire logic analogOnSignal,
    input wire logic abortEscapeButton,
    input wire logic outputToggleButton,
    input wire logic panelMenuButton,
    input wire logic hostCmdValid,
    input wire logic hostCmdIsSetting,
    input wire logic hostCmdListen,
    input wire logic hostCmdClearStatus,
    input wire logic hostCmdOutputOn,
    input wire logic hostCmdOutputOff,
    input wire logic errorEvent,
    input wire logic regulatingCurrent,
    input wire logic [RATE_W-1:0] voltageRampRate,
    input wire logic [RATE_W-1:0] currentRampRate,
    input wire logic [SET_W-1:0] analogVoltageIn,
    input wire logic [SET_W-1:0] analogCurrentIn,
    input wire logic [OUT_W-1:0] panelVoltageSet,
    input wire logic [OUT_W-1:0] panelCurrentSet,
    input wire logic [OUT_W-1:0] hostVoltageSet,
    input wire logic [OUT_W-1:0] hostCurrentSet,
    output logic outputEnable,
    output logic rampStart,
    output logic [RATE_W-1:0] rampRate,
    output logic [OUT_W-1:0] voltageSetpoint,
    output logic [OUT_W-1:0] currentSetpoint,
    output logic errorLamp,
    output logic showErrorView,
    output logic remoteLamp,
    output logic listeningMode,
    output logic [1:0] controlMode
);

    localparam int ALT_CW = $clog2(ALT_CYCLES + 1);
    localparam logic [ALT_CW-1:0] ALT_LAST = ALT_CW'(ALT_CYCLES - 1);

    typedef struct packed
    {
        logic started;
        sca_mode_e mode;
        logic listening;
        logic outputOn;
        logic errorActive;
        logic rampStart;
        logic analogOnPrev;
        logic showError;
        logic [ALT_CW-1:0] altCount;
        logic [RATE_W-1:0] rampRate;
        logic [OUT_W-1:0] voltageSet;
        logic [OUT_W-1:0] currentSet;
    } sca_arb_s;

    sca_arb_s s;
    sca_arb_s next_s;

    // ------------------------------------------------------------
    // Input conditioning
    // ------------------------------------------------------------
    logic disableRaw;
    logic disLevel;
    logic disRise;
    logic abortPress;
    logic togglePress;
    logic menuPress;

    // Open pin reads low, or high with the pull-up fitted
    assign disableRaw = disableLineOpen ? pullupDisableOption
                                        : disableLine;

    sca_debounce #(.CYCLES(DEB_CYCLES)) u_deb_disable
    (
        .clock(clock),
        .rst(rst),
        .raw(disableRaw),
        .level(disLevel),
        .rise(disRise)
    );

    sca_debounce #(.CYCLES(DEB_CYCLES)) u_deb_abort
    (
        .clock(clock),
        .rst(rst),
        .raw(abortEscapeButton),
        .level(),
        .rise(abortPress)
    );

    sca_debounce #(.CYCLES(DEB_CYCLES)) u_deb_toggle
    (
        .clock(clock),
        .rst(rst),
        .raw(outputToggleButton),
        .level(),
        .rise(togglePress)
    );

    sca_debounce #(.CYCLES(DEB_CYCLES)) u_deb_menu
    (
        .clock(clock),
        .rst(rst),
        .raw(panelMenuButton),
        .level(),
        .rise(menuPress)
    );

    // ------------------------------------------------------------
    // Source decisions
    // ------------------------------------------------------------
    logic panelActive;
    logic analogActive;
    logic hostMode;
    logic strapAnalog;
    logic hostBlocked;
    logic listenQuery;
    logic hostTakes;
    logic overridePress;
    logic hostAct;
    logic analogOnRise;
    logic onReq;
    logic offReq;
    logic clearReq;

    assign panelActive = s.started && s.mode == SCA_PANEL;
    assign analogActive = s.started && s.mode == SCA_ANALOG;
    assign hostMode = s.started && s.mode == SCA_HOST;
    assign strapAnalog = !hasPanel || storedAnalog;
    assign hostBlocked = hasPanel && analogActive;
    assign listenQuery = s.listening && !hostCmdIsSetting;
    // Panel-less analog units may be taken over here
    assign hostTakes = s.started && hostCmdValid && !hostCmdListen
                       && !hostMode && !hostBlocked && !listenQuery;
    assign overridePress = hostMode && s.outputOn
                           && (togglePress || menuPress);
    // Panel override beats a host command in the same cycle
    assign hostAct = hostCmdValid && (hostMode || hostTakes)
                     && !overridePress;
    assign analogOnRise = analogOnSignal && !s.analogOnPrev;

    always_comb
    begin
        onReq = 1'b0;
        offReq = 1'b0;
        if (analogActive)
        begin
            onReq = (disRise && analogOnSignal)
                    || (analogOnRise && disLevel);
            offReq = !analogOnSignal;
        end
        else if (panelActive)
        begin
            onReq = togglePress && !s.outputOn;
            offReq = togglePress && s.outputOn;
        end
        if (hostAct && hostCmdIsSetting)
        begin
            onReq = onReq || hostCmdOutputOn;
            offReq = offReq || hostCmdOutputOff;
        end
        // Errors refuse turn-on, a cleared error needs a new request
        onReq = onReq && !s.errorActive && !errorEvent
                && disLevel && !s.outputOn;
        offReq = offReq || errorEvent || !disLevel
                 || overridePress;
        clearReq = abortPress
                   || (analogActive && disRise)
                   || (hostAct && hostCmdClearStatus);
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb
    begin
        next_s = s;
        next_s.rampStart = 1'b0;
        next_s.analogOnPrev = analogOnSignal;
        next_s.rampRate = regulatingCurrent ? currentRampRate
                                            : voltageRampRate;

        if (!s.started)
        begin
            next_s.started = 1'b1;
            next_s.mode = strapAnalog ? SCA_ANALOG : SCA_PANEL;
        end
        else if (overridePress)
        begin
            next_s.mode = SCA_PANEL;
        end
        else if (hostTakes)
        begin
            next_s.mode = SCA_HOST;
        end
        else if (panelActive && hasPanel && storedAnalog)
        begin
            next_s.mode = SCA_ANALOG;
        end
        else if (analogActive && hasPanel && !storedAnalog)
        begin
            next_s.mode = SCA_PANEL;
        end

        if (hostCmdValid && hostCmdListen)
        begin
            next_s.listening = 1'b1;
        end
        else if (hostTakes && hostCmdIsSetting)
        begin
            next_s.listening = 1'b0;
        end

        if (offReq)
        begin
            next_s.outputOn = 1'b0;
        end
        else if (onReq)
        begin
            next_s.outputOn = 1'b1;
            next_s.rampStart = 1'b1;
        end

        // Set wins over clear so no event is lost
        next_s.errorActive = errorEvent
                             || (s.errorActive && !clearReq);

        if (!next_s.errorActive)
        begin
            next_s.showError = 1'b0;
            next_s.altCount = '0;
        end
        else if (!s.errorActive)
        begin
            next_s.showError = 1'b1;
            next_s.altCount = '0;
        end
        else if (s.altCount == ALT_LAST)
        begin
            next_s.showError = !s.showError;
            next_s.altCount = '0;
        end
        else
        begin
            next_s.altCount = s.altCount + 1'b1;
        end

        case (s.mode)
            SCA_ANALOG:
            begin
                next_s.voltageSet = sca_scale(analogVoltageIn,
                                              NOMINAL_VOLTAGE);
                next_s.currentSet = sca_scale(analogCurrentIn,
                                              NOMINAL_CURRENT);
            end
            SCA_HOST:
            begin
                next_s.voltageSet = hostVoltageSet;
                next_s.currentSet = hostCurrentSet;
            end
            default:
            begin
                next_s.voltageSet = panelVoltageSet;
                next_s.currentSet = panelCurrentSet;
            end
        endcase
    end

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            s <= '0;
            s.mode <= MODE_RESET;
        end
        else
        begin
            s <= next_s;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign outputEnable = s.outputOn;
    assign rampStart = s.rampStart;
    assign rampRate = s.rampRate;
    assign voltageSetpoint = s.voltageSet;
    assign currentSetpoint = s.currentSet;
    assign errorLamp = s.errorActive;
    assign showErrorView = s.showError;
    assign remoteLamp = s.mode == SCA_HOST;
    assign listeningMode = s.listening;
    assign controlMode = s.mode;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_error_forces_off: assert property (@(posedge clock)
        disable iff (rst)
        errorEvent |=> !outputEnable)
        else $error("output stayed on after an error event");

    a_error_refuses_on: assert property (@(posedge clock)
        disable iff (rst)
        s.errorActive && !s.outputOn |=> !outputEnable)
        else $error("output turned on while an error was active");

    a_error_view_flip: assert property (@(posedge clock)
        disable iff (rst)
        errorLamp && $past(errorLamp)
        && showErrorView != $past(showErrorView)
        |-> $past(s.altCount) == ALT_LAST)
        else $error("error view changed before half a second");

    a_error_view_first: assert property (@(posedge clock)
        disable iff (rst)
        $rose(errorLamp) |-> showErrorView)
        else $error("error message not shown first");

    a_abort_clears: assert property (@(posedge clock)
        disable iff (rst)
        abortPress && !errorEvent |=> !errorLamp)
        else $error("abort press did not clear the error");

    a_start_mode: assert property (@(posedge clock)
        disable iff (rst)
        $rose(s.started) |-> s.mode ==
        ($past(strapAnalog) ? SCA_ANALOG : SCA_PANEL))
        else $error("wrong control source after start");

    a_panel_no_line_on: assert property (@(posedge clock)
        disable iff (rst)
        panelActive && !togglePress && !hostCmdValid && !s.outputOn
        |=> !outputEnable)
        else $error("panel mode turned on without the toggle button");

    a_host_blocked: assert property (@(posedge clock)
        disable iff (rst)
        hostBlocked |=> controlMode != SCA_HOST)
        else $error("analog setting passed control straight to host");

    a_listen_monitor: assert property (@(posedge clock)
        disable iff (rst)
        s.started && s.listening && hostCmdValid && !hostCmdIsSetting
        && !hostMode |=> !remoteLamp)
        else $error("query in listening mode took control");

    a_host_lamp: assert property (@(posedge clock)
        disable iff (rst)
        hostTakes |=> remoteLamp ##1 remoteLamp || !hostMode)
        else $error("host command did not light the remote lamp");

    a_override_panel: assert property (@(posedge clock)
        disable iff (rst)
        overridePress |=> !outputEnable && controlMode == SCA_PANEL)
        else $error("panel override did not switch off to panel");

    a_line_low_off: assert property (@(posedge clock)
        disable iff (rst)
        !disLevel |=> !outputEnable)
        else $error("output on while the disable line is low");

    a_ramp_on_edge: assert property (@(posedge clock)
        disable iff (rst)
        rampStart |-> outputEnable && !$past(outputEnable)
        && rampRate == ($past(regulatingCurrent) ?
        $past(currentRampRate) : $past(voltageRampRate)))
        else $error("ramp start without a turn-on or wrong rate");

    a_analog_scale: assert property (@(posedge clock)
        disable iff (rst)
        $past(s.mode) == SCA_ANALOG |-> voltageSetpoint ==
        sca_scale($past(analogVoltageIn), NOMINAL_VOLTAGE))
        else $error("analog voltage setpoint not scaled");

    a_clear_stays_off: assert property (@(posedge clock)
        disable iff (rst)
        $fell(errorLamp) |-> !outputEnable)
        else $error("clearing an error turned the output on");

endmodule : sca_arbiter

// >>> testbench/sca_far_model.sv
// Far side of the arbiter: panel buttons, disable pin and host link.
// Assumes the bench calls its tasks just after a rising clock edge.
`timescale 1ns/1ps

module sca_far_model
    import sca_pkg::*;
(
    input wire logic clock,
    input wire logic disableDrive,
    input wire logic disableLineOpen,
    input wire logic pullupDisableOption,
    output logic disableLine,
    output logic [2:0] buttons,
    output logic [5:0] hostCmd
);
    // ------------------------------------------------------------
    // Pins and strobes
    // ------------------------------------------------------------
    // Open pin settles to the resistor level of the option
    assign disableLine = disableLineOpen ? pullupDisableOption
                                         : disableDrive;

    initial
    begin
        buttons = 3'h0;
        hostCmd = 6'h0;
    end

    // Held well past the debounce time so no press is lost
    task automatic press(input int b);
        @(posedge clock);
        buttons[b] <= 1'b1;
        repeat (10) @(posedge clock);
        buttons[b] <= 1'b0;
        repeat (10) @(posedge clock);
    endtask : press

    // One-cycle command strobe, qualifiers dropped with it
    task automatic send(input logic [4:0] q);
        @(posedge clock);
        hostCmd <= {1'b1, q};
        @(posedge clock);
        hostCmd <= 6'h0;
    endtask : send
endmodule : sca_far_model

// >>> testbench/tb.sv
// Self-checking bench of the control-source arbiter.
// Assumes the far-side model drives buttons, disable pin and host.
`timescale 1ns/1ps
`define CHK(g, e) check(32'(g), 32'(e))

module tb
    import sca_pkg::*;
;
    localparam logic [OUT_W-1:0] NOM = 16'h8000;
    logic clock = 1'b0;
    logic rst;
    logic hasPanel, storedAnalog;
    logic pullupDisableOption, disableLineOpen;
    logic disDrive, analogOnSignal;
    logic errorEvent, regulatingCurrent;
    logic [RATE_W-1:0] voltageRampRate, currentRampRate;
    logic [SET_W-1:0] analogVoltageIn, analogCurrentIn;
    logic [OUT_W-1:0] panelVoltageSet, panelCurrentSet;
    logic [OUT_W-1:0] hostVoltageSet, hostCurrentSet;
    logic disableLine, outputEnable, rampStart, errorLamp;
    logic showErrorView, remoteLamp, listeningMode, lastView;
    logic [2:0] buttons;
    logic [5:0] hostCmd;
    logic [RATE_W-1:0] rampRate;
    logic [OUT_W-1:0] voltageSetpoint, currentSetpoint;
    logic [1:0] controlMode;
    int seed = 95001;
    int nMismatch = 0;
    int nCompared = 0;
    int cycles = 0;
    int flips;

    always #10 clock = ~clock;

    sca_far_model sca_far_model_i (.clock, .disableDrive(disDrive),
        .disableLineOpen, .pullupDisableOption, .disableLine,
        .buttons, .hostCmd);

    // Short counts keep the run brief; expectations use the same
    sca_arbiter #(.ALT_CYCLES(8), .DEB_CYCLES(3),
        .NOMINAL_VOLTAGE(NOM), .NOMINAL_CURRENT(NOM)) sca_arbiter_i (
        .clock, .rst, .hasPanel, .storedAnalog, .pullupDisableOption,
        .disableLine, .disableLineOpen, .analogOnSignal,
        .abortEscapeButton(buttons[0]), .outputToggleButton(buttons[1]),
        .panelMenuButton(buttons[2]), .hostCmdValid(hostCmd[5]),
        .hostCmdIsSetting(hostCmd[4]), .hostCmdListen(hostCmd[3]),
        .hostCmdClearStatus(hostCmd[2]), .hostCmdOutputOn(hostCmd[1]),
        .hostCmdOutputOff(hostCmd[0]), .errorEvent, .regulatingCurrent,
        .voltageRampRate, .currentRampRate, .analogVoltageIn,
        .analogCurrentIn, .panelVoltageSet, .panelCurrentSet,
        .hostVoltageSet, .hostCurrentSet, .outputEnable, .rampStart,
        .rampRate, .voltageSetpoint, .currentSetpoint, .errorLamp,
        .showErrorView, .remoteLamp, .listeningMode, .controlMode);

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic check(input logic [31:0] g, input logic [31:0] e);
        nCompared++;
        if (g !== e)
        begin
            nMismatch++;
            $display("unexpected at %0t: got %h expected %h", $time, g, e);
        end
    endtask : check

    task automatic giveVerdict();
        if (nMismatch == 0 && nCompared > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : giveVerdict

    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
    endtask : cyc

    function automatic logic [OUT_W-1:0] scl(input logic [SET_W-1:0] c);
        return 16'((32'(c) * 32'(NOM)) >> SET_W);
    endfunction : scl

    // Fresh random setpoints and rates with every reset
    task automatic doReset(input logic panel, input logic analog);
        @(posedge clock);
        rst <= 1'b1;
        hasPanel <= panel;
        storedAnalog <= analog;
        regulatingCurrent <= 1'($random(seed));
        voltageRampRate <= 16'($random(seed));
        currentRampRate <= 16'($random(seed));
        analogVoltageIn <= 12'($random(seed));
        analogCurrentIn <= 12'($random(seed));
        panelVoltageSet <= 16'($random(seed));
        panelCurrentSet <= 16'($random(seed));
        hostVoltageSet <= 16'($random(seed));
        hostCurrentSet <= 16'($random(seed));
        cyc(6);
        rst <= 1'b0;
        cyc(4);
    endtask : doReset

    task automatic pulseError();
        errorEvent <= 1'b1;
        cyc(1);
        errorEvent <= 1'b0;
        cyc(1);
    endtask : pulseError

    always @(posedge clock)
    begin
        cycles <= cycles + 1;
        if (cycles == 3000)
        begin
            nMismatch++;
            giveVerdict();
        end
    end

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    initial
    begin
        // Driven here, not at declaration, so every input stays a live net
        rst <= 1'b1;
        hasPanel <= 1'b1;
        storedAnalog <= 1'b0;
        pullupDisableOption <= 1'b0;
        disableLineOpen <= 1'b0;
        disDrive <= 1'b0;
        analogOnSignal <= 1'b0;
        errorEvent <= 1'b0;
        regulatingCurrent <= 1'b0;
        voltageRampRate <= '0;
        currentRampRate <= '0;
        analogVoltageIn <= '0;
        analogCurrentIn <= '0;
        panelVoltageSet <= '0;
        panelCurrentSet <= '0;
        hostVoltageSet <= '0;
        hostCurrentSet <= '0;
        doReset(1'b1, 1'b0);
        `CHK(controlMode, 2'h0);
        disDrive <= 1'b1;
        cyc(10);
        `CHK(outputEnable, 1'b0);
        sca_far_model_i.press(1);
        `CHK(outputEnable, 1'b1);
        `CHK(rampRate, regulatingCurrent ? currentRampRate
                                         : voltageRampRate);
        `CHK(voltageSetpoint, panelVoltageSet);
        disDrive <= 1'b0;
        cyc(10);
        `CHK(outputEnable, 1'b0);
        disDrive <= 1'b1;
        sca_far_model_i.press(1);
        pulseError();
        `CHK({errorLamp, showErrorView, outputEnable}, 3'h6);
        lastView = showErrorView;
        flips = 0;
        repeat (36)
        begin
            @(posedge clock);
            flips += int'(showErrorView !== lastView);
            lastView = showErrorView;
        end
        `CHK(flips, 4);
        sca_far_model_i.press(1);
        `CHK(outputEnable, 1'b0);
        sca_far_model_i.press(0);
        `CHK(errorLamp, 1'b0);
        `CHK(outputEnable, 1'b0);
        sca_far_model_i.press(1);
        sca_far_model_i.send(5'h00);
        cyc(1);
        `CHK({controlMode, remoteLamp}, 3'h7);
        sca_far_model_i.send(5'h12);
        cyc(2);
        `CHK(hostCurrentSet, currentSetpoint);
        sca_far_model_i.press(2);
        `CHK({controlMode, outputEnable}, 3'h0);
        sca_far_model_i.send(5'h00);
        cyc(1);
        `CHK(controlMode, 2'h3);
        pulseError();
        sca_far_model_i.send(5'h04);
        cyc(1);
        `CHK(errorLamp, 1'b0);
        // Listening interface
        doReset(1'b1, 1'b0);
        sca_far_model_i.send(5'h08);
        sca_far_model_i.send(5'h00);
        cyc(1);
        `CHK({listeningMode, controlMode}, 3'h4);
        sca_far_model_i.send(5'h10);
        cyc(1);
        `CHK(controlMode, 2'h3);
        // Analog port with a panel fitted, full-scale code
        doReset(1'b1, 1'b1);
        analogVoltageIn <= 12'hfff;
        cyc(3);
        `CHK(controlMode, 2'h1);
        `CHK(voltageSetpoint, scl(12'hfff));
        `CHK(currentSetpoint, scl(analogCurrentIn));
        analogOnSignal <= 1'b1;
        cyc(4);
        `CHK(outputEnable, 1'b1);
        sca_far_model_i.send(5'h12);
        cyc(1);
        `CHK(controlMode, 2'h1);
        disDrive <= 1'b0;
        cyc(10);
        `CHK(outputEnable, 1'b0);
        pulseError();
        disDrive <= 1'b1;
        cyc(10);
        `CHK({errorLamp, outputEnable}, 2'h0);
        disDrive <= 1'b0;
        cyc(10);
        disDrive <= 1'b1;
        cyc(10);
        `CHK(outputEnable, 1'b1);
        // Panel-less unit, pin left open with the pull-up option
        analogOnSignal <= 1'b0;
        pullupDisableOption <= 1'b1;
        disableLineOpen <= 1'b1;
        doReset(1'b0, 1'b0);
        `CHK(controlMode, 2'h1);
        analogOnSignal <= 1'b1;
        cyc(4);
        `CHK(outputEnable, 1'b1);
        pullupDisableOption <= 1'b0;
        cyc(10);
        `CHK(outputEnable, 1'b0);
        sca_far_model_i.send(5'h00);
        cyc(1);
        `CHK(controlMode, 2'h3);
        giveVerdict();
    end
endmodule : tb
